/* tluc_defs.svh */
`ifndef TLUC_DEFS_SVH
`define TLUC_DEFS_SVH
// timebase
`define TLUC_CLK_HZ         25000000
// least pulse width accepted, in microseconds
`define TLUC_MIN_PULSE_US   20
// clock kept a whole number of MHz so every product stays inside 32 bits
`define TLUC_MIN_PULSE_CYC  (`TLUC_MIN_PULSE_US * (`TLUC_CLK_HZ / 1000000))
// programming level must persist longer than this, microseconds
`define TLUC_PROG_HOLD_US   200
`define TLUC_PROG_HOLD_CYC  (`TLUC_PROG_HOLD_US * (`TLUC_CLK_HZ / 1000000) + 1)
// reload time, milliseconds
`define TLUC_RELOAD_MS      10
`define TLUC_RELOAD_CYC     ((`TLUC_RELOAD_MS * `TLUC_CLK_HZ) / 1000)
// longest write time, milliseconds
`define TLUC_WRITE_MS       100
`define TLUC_WRITE_CYC      (`TLUC_WRITE_MS * (`TLUC_CLK_HZ / 1000))
// counter
`define TLUC_CNT_W          8
`define TLUC_CNT_MAX        8'hff
`define TLUC_CNT_MIN        8'h00
`define TLUC_FACTORY_VAL    8'h80
`endif

/* tluc_pkg.sv */
package tluc_pkg;
    // zones of the tri-level control pin
    typedef enum logic [1:0] {
        TLUC_ZONE_LOW,
        TLUC_ZONE_MID,
        TLUC_ZONE_HIGH,
        TLUC_ZONE_PROG
    } tluc_zone_type;
    // pulse tracking states
    typedef enum logic [2:0] {
        TLUC_ST_IDLE,
        TLUC_ST_LOW,
        TLUC_ST_HIGH,
        TLUC_ST_PROG,
        TLUC_ST_WAIT
    } tluc_state_type;
endpackage : tluc_pkg

/* tluc_nvm_if.sv */
`timescale 1ns/1ns
interface tluc_nvm_if;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic       busy;
    modport ctrl (output wr_stb, output wr_data, input rd_data, input busy);
    modport mem  (input wr_stb, input wr_data, output rd_data, output busy);
endinterface : tluc_nvm_if

/* tluc_nvm.sv */
`timescale 1ns/1ns
`include "tluc_defs.svh"
// non-volatile cell model: flip-flop image with a timed write window
module tluc_nvm #(
    parameter int WRITE_CYC = `TLUC_WRITE_CYC
) (
    input  wire logic  i_mclk,
    input  wire logic  i_rstn,
    input  wire logic  i_ce,
    tluc_nvm_if.mem    nvm
);
    logic [7:0]  image;
    logic [7:0]  next_image;
    logic [31:0] wcnt;
    logic [31:0] next_wcnt;

    // image survives reset in silicon; here reset restores factory mid-scale
    always_comb begin
        next_image = image;
        next_wcnt  = wcnt;
        if (nvm.wr_stb && wcnt == 32'h0) begin
            next_image = nvm.wr_data;
            next_wcnt  = 32'(WRITE_CYC);
        end else if (wcnt != 32'h0) begin
            next_wcnt = wcnt - 32'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            image <= `TLUC_FACTORY_VAL;
            wcnt  <= 32'h0;
        end else if (i_ce) begin
            image <= next_image;
            wcnt  <= next_wcnt;
        end
    end

    assign nvm.rd_data = image;
    assign nvm.busy    = (wcnt != 32'h0);
endmodule : tluc_nvm

/* tluc_counter.sv */
`timescale 1ns/1ns
`include "tluc_defs.svh"
module tluc_counter
    import tluc_pkg::*;
#(
    parameter int CNT_W      = `TLUC_CNT_W,
    parameter int MIN_CYC    = `TLUC_MIN_PULSE_CYC,
    parameter int PROG_CYC   = `TLUC_PROG_HOLD_CYC,
    parameter int RELOAD_CYC = `TLUC_RELOAD_CYC,
    parameter int WRITE_CYC  = `TLUC_WRITE_CYC
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_clk_en,
    input  wire tluc_pkg::tluc_zone_type i_tri_level_control_pin,
    input  wire logic                  i_count_enable,
    input  wire logic                  i_count_enable_driven,
    output logic [CNT_W-1:0]           o_count,
    output logic                       o_reloading,
    output logic                       o_nvm_busy
);
    tluc_nvm_if nvm_bus ();

    tluc_state_type   state;
    tluc_state_type   next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [31:0]      pw;
    logic [31:0]      next_pw;
    logic [31:0]      rl;
    logic [31:0]      next_rl;
    logic             skip;
    logic             next_skip;
    logic             en_q;
    logic             boot;
    logic             next_boot;
    logic             wr_stb;
    logic             next_wr_stb;
    logic             ld_stb;
    logic             next_ld_stb;
    logic             nvm_busy;
    logic             en;

    // saturating step; shared by both count directions
    // holding at the rails instead of wrapping keeps a stuck button
    // from walking the output across its whole range
    function automatic logic [CNT_W-1:0] sat_step(input logic [CNT_W-1:0] v,
                                                  input logic up);
        if (up)
            sat_step = (v == `TLUC_CNT_MAX) ? v : v + 1'b1;
        else
            sat_step = (v == `TLUC_CNT_MIN) ? v : v - 1'b1;
    endfunction : sat_step

    // floating enable is forced low, mirroring the internal pull-down
    // a floating enable must never arm a count or a write
    assign en = i_count_enable & i_count_enable_driven;

    // cell model shares the clock enable, so a frozen timebase also
    // stretches the write window instead of letting it run out unseen
    tluc_nvm #(
        .WRITE_CYC (WRITE_CYC)
    ) u_nvm (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .i_ce   (i_clk_en),
        .nvm    (nvm_bus.mem)
    );
    // write data is the live count; it lands on a strobe that finds the cell idle
    assign nvm_bus.wr_stb  = wr_stb;
    assign nvm_bus.wr_data = count;

    // pulse tracker, reload timer, strobes
    // pulse widths are counted in enabled samples of the timebase, so the
    // glitch filter scales with the clock; a pulse split by a reload is lost
    always_comb begin
        next_state  = state;
        next_count  = count;
        next_pw     = pw;
        next_rl     = rl;
        next_skip   = skip;
        next_boot   = 1'b0;
        next_wr_stb = 1'b0;
        next_ld_stb = 1'b0;
        if (boot) begin
            next_ld_stb = 1'b1;
        end
        if (ld_stb) begin
            next_count = nvm_bus.rd_data;
        end
        if (en_q && !en) begin
            // reload takes its full time; driver keeps inputs still meanwhile
            next_rl    = 32'(RELOAD_CYC);
            next_state = TLUC_ST_IDLE;
        end else if (rl != 32'h0) begin
            next_rl = rl - 32'h1;
            if (rl == 32'h1) begin
                next_ld_stb = 1'b1;
            end
        end
        // enable rising: the next valid pulse only clears the skip
        if (!en_q && en) begin
            next_skip = 1'b1;
        end
        // nothing is tracked while disabled, reloading or loading; a pulse
        // in flight when the enable drops is simply forgotten
        if (en && rl == 32'h0 && !ld_stb && !boot) begin
            case (state)
                TLUC_ST_IDLE: begin
                    next_pw = 32'h1;
                    case (i_tri_level_control_pin)
                        TLUC_ZONE_LOW:  next_state = TLUC_ST_LOW;
                        TLUC_ZONE_HIGH: next_state = TLUC_ST_HIGH;
                        TLUC_ZONE_PROG: next_state = TLUC_ST_PROG;
                        default:        next_state = TLUC_ST_IDLE;
                    endcase
                end
                TLUC_ST_LOW, TLUC_ST_HIGH: begin
                    if (i_tri_level_control_pin == TLUC_ZONE_PROG) begin
                        next_state = TLUC_ST_PROG;
                        next_pw    = 32'h1;
                    end else if (i_tri_level_control_pin == TLUC_ZONE_MID) begin
                        next_state = TLUC_ST_IDLE;
                        if (pw >= 32'(MIN_CYC)) begin
                            if (skip)
                                next_skip = 1'b0;
                            else
                                next_count = sat_step(count, state == TLUC_ST_LOW);
                        end
                    end else if (pw != 32'hffffffff) begin
                        next_pw = pw + 32'h1;
                    end
                end
                TLUC_ST_PROG: begin
                    if (i_tri_level_control_pin != TLUC_ZONE_PROG) begin
                        next_state = TLUC_ST_WAIT;
                    end else begin
                        // width counter stops at its top so a very long hold
                        // never wraps round and writes a second time
                        if (pw != 32'hffffffff) begin
                            next_pw = pw + 32'h1;
                        end
                        // one write per hold, none while the cell is busy;
                        // pending loads already stall the whole tracker
                        if (pw == 32'(PROG_CYC) && !nvm_busy) begin
                            next_wr_stb = 1'b1;
                        end
                    end
                end
                TLUC_ST_WAIT: begin
                    // leaving programming arms the skip only once back at mid
                    if (i_tri_level_control_pin == TLUC_ZONE_MID) begin
                        next_state = TLUC_ST_IDLE;
                        next_skip  = 1'b1;
                    end
                end
                default: next_state = TLUC_ST_IDLE;
            endcase
        end
    end

    // register stage
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state     <= TLUC_ST_IDLE;
            count     <= `TLUC_FACTORY_VAL;
            pw        <= 32'h0;
            rl        <= 32'h0;
            skip      <= 1'b1;
            en_q      <= 1'b0;
            boot      <= 1'b1;
            wr_stb    <= 1'b0;
            ld_stb    <= 1'b0;
            nvm_busy  <= 1'b0;
        end else if (i_clk_en) begin
            state     <= next_state;
            count     <= next_count;
            pw        <= next_pw;
            rl        <= next_rl;
            skip      <= next_skip;
            en_q      <= en;
            boot      <= next_boot;
            wr_stb    <= next_wr_stb;
            ld_stb    <= next_ld_stb;
            nvm_busy  <= nvm_bus.busy;
        end
    end

    // pin-facing copies, each straight from its own flop; the count copy
    // follows next_count so it never lags the internal register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count     <= `TLUC_FACTORY_VAL;
            o_reloading <= 1'b0;
            o_nvm_busy  <= 1'b0;
        end else if (i_clk_en) begin
            o_count     <= next_count;
            o_reloading <= (next_rl != 32'h0);
            o_nvm_busy  <= nvm_bus.busy;
        end
    end
endmodule : tluc_counter

/* tluc_counter_assertions.sv */
`timescale 1ns/1ns
`include "tluc_defs.svh"
module tluc_counter_assertions
    import tluc_pkg::*;
#(
    parameter int CNT_W      = `TLUC_CNT_W,
    parameter int MIN_CYC    = `TLUC_MIN_PULSE_CYC,
    parameter int PROG_CYC   = `TLUC_PROG_HOLD_CYC,
    parameter int RELOAD_CYC = `TLUC_RELOAD_CYC,
    parameter int WRITE_CYC  = `TLUC_WRITE_CYC
) (
    input wire logic                    i_mclk,
    input wire logic                    i_rstn,
    input wire logic                    i_clk_en,
    input wire tluc_pkg::tluc_zone_type i_tri_level_control_pin,
    input wire logic                    i_count_enable,
    input wire logic                    i_count_enable_driven,
    input wire logic [CNT_W-1:0]        o_count,
    input wire logic                    o_reloading,
    input wire logic                    o_nvm_busy
);
    tluc_zone_type pin, last_act;
    logic [31:0]   run, last_len, prog_run, rl_cnt;
    logic [3:0]    rlh;
    logic          quiet;
    // a reload may move the count freely, so mask a few cycles around it
    assign pin = i_tri_level_control_pin;
    assign quiet = !o_reloading && rlh == 4'h0;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // pulse length and window counters
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            {run, last_len, prog_run, rl_cnt, rlh} <= '0;
            last_act <= TLUC_ZONE_MID;
        end else begin
            run <= (pin == TLUC_ZONE_LOW || pin == TLUC_ZONE_HIGH) ? run + 32'h1 : 32'h0;
            prog_run <= (pin == TLUC_ZONE_PROG) ? prog_run + 32'h1 : 32'h0;
            rl_cnt <= o_reloading ? rl_cnt + 32'h1 : 32'h0;
            rlh <= {rlh[2:0], o_reloading};
            if (pin == TLUC_ZONE_LOW || pin == TLUC_ZONE_HIGH) last_act <= pin;
            if (pin == TLUC_ZONE_MID && run != 32'h0) last_len <= run;
        end
    end
    up_cause_a: assert property (
        quiet && o_count == $past(o_count) + 1'b1 |-> last_act == TLUC_ZONE_LOW)
        else $error("up without low pulse");
    down_cause_a: assert property (
        quiet && o_count == $past(o_count) - 1'b1 |-> last_act == TLUC_ZONE_HIGH)
        else $error("down without high pulse");
    pulse_width_a: assert property (
        quiet && $changed(o_count) |-> last_len >= MIN_CYC) else $error("short pulse counted");
    enable_gate_a: assert property (
        quiet && $changed(o_count) |-> $past(i_count_enable && i_count_enable_driven, 2))
        else $error("count while disabled");
    reload_start_a: assert property (
        i_clk_en && $fell(i_count_enable && i_count_enable_driven) && !o_reloading
        |=> o_reloading) else $error("reload not started");
    reload_len_a: assert property (
        $fell(o_reloading) |-> rl_cnt == RELOAD_CYC) else $error("reload length");
    prog_hold_a: assert property (
        pin == TLUC_ZONE_PROG && $past(pin) == TLUC_ZONE_PROG |=> $stable(o_count))
        else $error("count moved while programming");
    write_delay_a: assert property (
        $rose(o_nvm_busy) |-> prog_run >= PROG_CYC) else $error("early write");
    up_seen_c: cover property (quiet && o_count == $past(o_count) + 1'b1);
    reload_seen_c: cover property ($fell(o_reloading));
    write_seen_c: cover property ($rose(o_nvm_busy));
endmodule : tluc_counter_assertions

/* tluc_ctl_model.sv */
`timescale 1ns/1ns
module tluc_ctl_model
    import tluc_pkg::*;
(
    input  wire logic               i_mclk,
    output tluc_pkg::tluc_zone_type o_pin,
    output logic                    o_ce,
    output logic                    o_ce_driven
);
    // pin idles at its mid bias, enable starts driven low
    initial begin
        o_pin = TLUC_ZONE_MID;
        o_ce = 1'b0;
        o_ce_driven = 1'b1;
    end
    // hold one zone for n samples, then release to the mid bias
    task automatic press(input tluc_zone_type z, input int n);
        @(negedge i_mclk);
        o_pin = z;
        repeat (n) @(negedge i_mclk);
        o_pin = TLUC_ZONE_MID;
        repeat (3) @(negedge i_mclk);
    endtask : press
    // a floated enable keeps no trusted level, so show the opposite one
    task automatic enable(input logic v, input logic on);
        @(negedge i_mclk);
        o_ce_driven = on;
        o_ce = on ? v : ~o_ce;
    endtask : enable
endmodule : tluc_ctl_model

/* tri_level_updown_counter_nvm_tb.sv */
`timescale 1ns/1ns
module tri_level_updown_counter_nvm_tb;
    import tluc_pkg::*;
    localparam int MIN = 4;
    localparam int RLD = 20;
    localparam int WR  = 50;
    logic          i_mclk = 1'b0;
    logic          i_rstn = 1'b0;
    tluc_zone_type pin;
    logic          ce, ce_drv, reloading, busy, skip, en;
    logic          clk_en = 1'b1;
    logic [7:0]    cnt, model, stored;
    logic [7:0]    exp_q[$];
    int            error_cnt = 0;
    int            n_checks = 0;
    int            seed = 32'hcb79;
    event          note;
    // 25 MHz clock
    always #20 i_mclk = ~i_mclk;
    tluc_counter #(.MIN_CYC(MIN), .PROG_CYC(10), .RELOAD_CYC(RLD), .WRITE_CYC(WR)) uut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_clk_en(clk_en), .i_tri_level_control_pin(pin),
        .i_count_enable(ce), .i_count_enable_driven(ce_drv), .o_count(cnt),
        .o_reloading(reloading), .o_nvm_busy(busy));
    tluc_ctl_model drv (.i_mclk(i_mclk), .o_pin(pin), .o_ce(ce), .o_ce_driven(ce_drv));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("FAIL %0t saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic results;
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    // post an expectation once the count has settled
    task automatic post(input logic [7:0] v);
        repeat (3) @(negedge i_mclk);
        exp_q.push_back(v);
        -> note;
    endtask : post
    // one pulse, mirrored in the reference count
    task automatic step(input logic up, input int w);
        drv.press(up ? TLUC_ZONE_LOW : TLUC_ZONE_HIGH, w);
        if (w >= MIN && en) begin
            if (skip) skip = 1'b0;
            else if (up && model != 8'hff) model = model + 8'h01;
            else if (!up && model != 8'h00) model = model - 8'h01;
        end
    endtask : step
    // inputs stay put through any reload that follows
    task automatic set_en(input logic v, input logic on);
        logic was;
        was = en;
        drv.enable(v, on);
        en = v && on;
        skip = 1'b1;
        if (!en) begin
            repeat (2) @(negedge i_mclk);
            check({7'h0, reloading}, {7'h0, was});
            repeat (RLD + 6) @(negedge i_mclk);
            model = stored;
        end
    endtask : set_en
    // compare each posted count on the next edge
    always @(note) begin
        @(posedge i_mclk);
        #1 check(cnt, exp_q.pop_front());
    end
    initial begin
        {model, stored, skip, en} = {8'h80, 8'h80, 2'b10};
        repeat (12) @(negedge i_mclk);
        i_rstn = 1'b1;
        post(8'h80);
        set_en(1'b1, 1'b1);
        step(1'b1, MIN);
        step(1'b1, MIN - 1);
        post(model);
        repeat (40) step(1'($random(seed)), MIN - 2 + ($random(seed) & 7));
        post(model);
        stored = model;
        drv.press(TLUC_ZONE_PROG, 30);
        skip = 1'b1;
        check({7'h0, busy}, 8'h01);
        post(model);
        repeat (WR) @(negedge i_mclk);
        check({7'h0, busy}, 8'h00);
        step(1'b0, MIN);
        step(1'b0, MIN);
        post(model);
        set_en(1'b0, 1'b1);
        post(model);
        step(1'b1, MIN);
        post(model);
        set_en(1'b1, 1'b1);
        step(1'b0, MIN);
        step(1'b0, MIN);
        set_en(1'b0, 1'b1);
        post(model);
        set_en(1'b1, 1'b0);
        repeat (2) step(1'b1, MIN);
        post(model);
        set_en(1'b1, 1'b1);
        repeat (300) step(1'b1, MIN);
        post(8'hff);
        repeat (300) step(1'b0, MIN);
        post(8'h00);
        // a frozen timebase must not see a full-width pulse
        @(negedge i_mclk);
        clk_en = 1'b0;
        drv.press(TLUC_ZONE_LOW, MIN);
        clk_en = 1'b1;
        post(model);
        repeat (4) @(negedge i_mclk);
        results();
    end
    // the run needs under 10k cycles, so this only trips on a hang
    initial begin
        repeat (30000) @(posedge i_mclk);
        error_cnt++;
        results();
    end
endmodule : tri_level_updown_counter_nvm_tb
bind tluc_counter tluc_counter_assertions #(.CNT_W(CNT_W), .MIN_CYC(MIN_CYC),
    .PROG_CYC(PROG_CYC), .RELOAD_CYC(RELOAD_CYC), .WRITE_CYC(WRITE_CYC)) chk (.*);
